// File: rtl/brs_pkg.sv
/*
  Constants, types and register map of the breaker reclose sequencer.
  Assumes a 10 MHz system clock and an APB master with 32-bit data.
*/
// Contract
// - A trip request while ready raises sequence active, request pending and the first attempt indication together.
// - With the breaker open and the request gone, the attempt's dead timer runs and its expiry issues a close request.
// - The close request holds until the breaker reports closed, then the attempt's reclaim timer starts.
// - A request during an attempt's reclaim time moves to the next enabled attempt and swaps the attempt indications.
// - A dead timer always runs to its full setting before closing, whatever the fault does meanwhile.
// - Reclaim expiry without a request drops sequence, attempt and pending indications and starts the overall guard.
// - A request during the overall guard goes to final trip and lock-out, unless a setting selects a new sequence.
// - Any timer set to zero is skipped and the sequence moves on at once.
// - A setting can omit the overall guard phase after a successful cycle.
// - Expiry of the overall guard returns the sequencer to ready for the next request.
// - Five individually enabled attempts, times from zero to 1800 s in 5 ms steps.
// - A request in reclaim with no further enabled attempt gives final trip, drops indications and locks out.
// - Lock-out is left only by the external reset or the breaker closing, once its cause has cleared.
// - An open or close failure time-out from the breaker control puts the sequencer in lock-out, except while ready, where it is ignored.
package brs_pkg;

  localparam int CLK_HZ       = 10_000_000;
  localparam int TICK_MS      = 5;
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int NUM_SHOTS    = 5;
  localparam int SHOT_W       = 3;
  localparam int TIME_W       = 19;
  localparam int ADDR_W       = 12;
  localparam int IRQ_W        = 3;

  localparam logic [TIME_W-1:0] TIME_MAX = 19'h5_7e40;

  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_SHOT_EN   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_GUARD     = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_DEAD_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_RECL_BASE = 12'h040;

  localparam int IRQ_START = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_LOCK  = 2;

  localparam logic [NUM_SHOTS-1:0] SHOT_EN_RST  = 5'h01;
  localparam logic [IRQ_W-1:0]     IRQ_MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_READY     = 3'b000,
    ST_WAIT_OPEN = 3'b001,
    ST_DEAD      = 3'b010,
    ST_CLOSE     = 3'b011,
    ST_RECLAIM   = 3'b100,
    ST_GUARD     = 3'b101,
    ST_FINAL     = 3'b110,
    ST_LOCKOUT   = 3'b111
  } brs_state_e;

  typedef struct packed {
    logic skip_guard;
    logic guard_restart;
    logic enable;
  } brs_ctrl_s;

  localparam brs_ctrl_s CTRL_RST = 3'h1;

  typedef struct packed {
    logic open;
    logic closed;
    logic open_fail;
    logic close_fail;
  } brs_brk_s;

endpackage : brs_pkg

// File: rtl/brs_seq_timer.sv
/*
  Shared sequence timer: 5 ms tick prescaler and a tick counter.
  Assumes the sequencer pulses restart whenever a timed step begins.
*/
`timescale 1ns/1ps
module brs_seq_timer import brs_pkg::*; #(
  parameter int TICKS  = TICK_CYCLES,
  parameter int TIME_W_P = TIME_W
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Control
  input  wire logic                restart,
  input  wire logic [TIME_W_P-1:0] limit,
  // Result
  output logic                     done
);
  localparam int PRE_W = $clog2(TICKS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICKS - 1);

  logic [PRE_W-1:0]    pre_r;
  logic [PRE_W-1:0]    pre_nxt;
  logic [TIME_W_P-1:0] cnt_r;
  logic [TIME_W_P-1:0] cnt_nxt;
  logic                tick;

  assign done = (limit == '0) || (cnt_r >= limit);
  assign tick = (pre_r == PRE_LAST);

  always_comb begin
    pre_nxt = tick ? '0 : pre_r + 1'b1;
    cnt_nxt = (tick && !done) ? cnt_r + 1'b1 : cnt_r;
    if (restart) begin
      pre_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
      cnt_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  chk_tick_count: assert property (@(posedge sys_clk) disable iff (rst)
    !restart && !tick |=> cnt_r == $past(cnt_r)) else $error("Timer moved without a tick");

endmodule : brs_seq_timer

// File: rtl/brs_sequencer.sv
/*
  Breaker reclose sequencer with APB register file and interrupt.
  Assumes trip request and breaker status are synchronous to sys_clk.
*/
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module brs_sequencer import brs_pkg::*; #(
  parameter int N_SHOTS = NUM_SHOTS,
  parameter int TICKS   = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Protection request and breaker control
  input  wire logic               request_two,
  input  wire brs_brk_s           brk,
  input  wire logic               ext_reset,
  // Indications
  output logic                    sequence_active,
  output logic                    request_two_pending,
  output logic [N_SHOTS-1:0]      attempt_active,
  output logic                    close_request,
  output logic                    post_cycle_guard,
  output logic                    final_trip,
  output logic                    reclose_lockout,
  output logic                    irq
);

  brs_state_e                st_r, st_nxt;
  logic [SHOT_W-1:0]         shot_r, shot_nxt;
  logic [IRQ_W-1:0]          evt;
  logic                      closed_prev_r;
  logic                      fail;

  brs_ctrl_s                 ctrl_r, ctrl_nxt;
  logic [N_SHOTS-1:0]        shot_en_r, shot_en_nxt;
  logic [TIME_W-1:0]         guard_r, guard_nxt;
  logic [TIME_W-1:0]         dead_r [N_SHOTS];
  logic [TIME_W-1:0]         dead_nxt [N_SHOTS];
  logic [TIME_W-1:0]         recl_r [N_SHOTS];
  logic [TIME_W-1:0]         recl_nxt [N_SHOTS];
  logic [IRQ_W-1:0]          irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0]          irq_mask_r, irq_mask_nxt;

  logic                      pready_r, pready_nxt;
  logic                      pslverr_r, pslverr_nxt;
  logic [31:0]               prdata_r, prdata_nxt;
  logic                      seq_active_r, seq_active_nxt;
  logic [N_SHOTS-1:0]        attempt_r, attempt_nxt;
  logic                      close_req_r, close_req_nxt;
  logic                      guard_out_r, guard_out_nxt;
  logic                      final_r, final_nxt;
  logic                      lock_r, lock_nxt;
  logic                      irq_r, irq_nxt;

  logic                      first_ok, next_ok;
  logic [SHOT_W-1:0]         first_idx, next_idx;
  logic [TIME_W-1:0]         limit;
  logic                      tmr_done;
  logic                      restart;

  // Lowest enabled shot, and lowest enabled shot above the current one
  always_comb begin
    first_ok  = 1'b0;
    next_ok   = 1'b0;
    first_idx = '0;
    next_idx  = '0;
    for (int i = N_SHOTS - 1; i >= 0; i--) begin
      if (shot_en_r[i]) begin
        first_ok  = 1'b1;
        first_idx = SHOT_W'(i);
        if (SHOT_W'(i) > shot_r) begin
          next_ok  = 1'b1;
          next_idx = SHOT_W'(i);
        end
      end
    end
  end

  always_comb begin
    limit = '0;
    if (st_r == ST_DEAD) begin
      limit = dead_r[shot_r];
    end else if (st_r == ST_RECLAIM) begin
      limit = recl_r[shot_r];
    end else if (st_r == ST_GUARD) begin
      limit = guard_r;
    end
  end

  assign restart = (st_nxt != st_r) || (shot_nxt != shot_r);
  assign fail    = brk.open_fail || brk.close_fail;

  brs_seq_timer #(
    .TICKS    (TICKS),
    .TIME_W_P (TIME_W)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .restart (restart),
    .limit   (limit),
    .done    (tmr_done)
  );

  // Sequence state machine
  always_comb begin
    st_nxt   = st_r;
    shot_nxt = shot_r;
    evt      = '0;
    case (st_r)
      ST_READY: begin
        if (ctrl_r.enable && request_two) begin
          evt[IRQ_START] = 1'b1;
          shot_nxt       = first_idx;
          st_nxt         = first_ok ? ST_WAIT_OPEN : ST_FINAL;
        end
      end
      ST_WAIT_OPEN: begin
        if (brk.open && !request_two) begin
          st_nxt = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (tmr_done) begin
          st_nxt = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (brk.closed) begin
          st_nxt = ST_RECLAIM;
        end
      end
      ST_RECLAIM: begin
        if (request_two) begin
          shot_nxt = next_ok ? next_idx : shot_r;
          st_nxt   = next_ok ? ST_WAIT_OPEN : ST_FINAL;
        end else if (tmr_done) begin
          st_nxt = ctrl_r.skip_guard ? ST_READY : ST_GUARD;
          evt[IRQ_DONE] = ctrl_r.skip_guard;
        end
      end
      ST_GUARD: begin
        if (request_two) begin
          shot_nxt = first_idx;
          st_nxt   = (ctrl_r.guard_restart && first_ok) ? ST_WAIT_OPEN : ST_FINAL;
          evt[IRQ_START] = ctrl_r.guard_restart && first_ok;
        end else if (tmr_done) begin
          st_nxt        = ST_READY;
          evt[IRQ_DONE] = 1'b1;
        end
      end
      ST_FINAL: begin
        st_nxt = ST_LOCKOUT;
      end
      ST_LOCKOUT: begin
        // leave only on reset or closing, cause cleared
        if ((ext_reset || (brk.closed && !closed_prev_r)) && !request_two && !fail) begin
          st_nxt = ST_READY;
        end
      end
      default: begin
        st_nxt = ST_READY;
      end
    endcase
    if (fail && st_r != ST_READY && st_r != ST_LOCKOUT) begin
      st_nxt = ST_LOCKOUT;
    end
    if (st_nxt == ST_LOCKOUT && st_r != ST_LOCKOUT) begin
      evt[IRQ_LOCK] = 1'b1;
    end
  end

  // Indications follow the next state
  always_comb begin
    seq_active_nxt = (st_nxt == ST_WAIT_OPEN) || (st_nxt == ST_DEAD) ||
                     (st_nxt == ST_CLOSE) || (st_nxt == ST_RECLAIM);
    close_req_nxt  = (st_nxt == ST_CLOSE);
    guard_out_nxt  = (st_nxt == ST_GUARD);
    final_nxt      = (st_nxt == ST_FINAL);
    lock_nxt       = (st_nxt == ST_LOCKOUT);
  end

  for (genvar g = 0; g < N_SHOTS; g++) begin : g_attempt
    assign attempt_nxt[g] = seq_active_nxt && (shot_nxt == SHOT_W'(g));
  end

  // APB register file
  logic wr_en;
  logic rd_en;
  logic dead_hit;
  logic recl_hit;
  logic [SHOT_W-1:0] reg_idx;
  logic [TIME_W-1:0] wr_time;

  assign wr_en    = psel && penable && pready_r && pwrite;
  assign rd_en    = psel && penable && !pready_r && !pwrite;
  assign reg_idx  = paddr[4:2];
  assign dead_hit = (paddr[ADDR_W-1:5] == ADDR_DEAD_BASE[ADDR_W-1:5]) && (reg_idx < SHOT_W'(N_SHOTS));
  assign recl_hit = (paddr[ADDR_W-1:5] == ADDR_RECL_BASE[ADDR_W-1:5]) && (reg_idx < SHOT_W'(N_SHOTS));
  assign wr_time  = (pwdata[31:TIME_W] != '0 || pwdata[TIME_W-1:0] > TIME_MAX) ? TIME_MAX : pwdata[TIME_W-1:0];

  always_comb begin
    ctrl_nxt     = ctrl_r;
    shot_en_nxt  = shot_en_r;
    guard_nxt    = guard_r;
    dead_nxt     = dead_r;
    recl_nxt     = recl_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    prdata_nxt   = prdata_r;
    pslverr_nxt  = 1'b0;
    pready_nxt   = psel && penable && !pready_r;
    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_nxt = pwdata[$bits(brs_ctrl_s)-1:0];
      end else if (paddr == ADDR_SHOT_EN) begin
        shot_en_nxt = pwdata[N_SHOTS-1:0];
      end else if (paddr == ADDR_GUARD) begin
        guard_nxt = wr_time;
      end else if (paddr == ADDR_IRQ_STAT) begin
        irq_stat_nxt = irq_stat_r & ~pwdata[IRQ_W-1:0];
      end else if (paddr == ADDR_IRQ_MASK) begin
        irq_mask_nxt = pwdata[IRQ_W-1:0];
      end else if (dead_hit) begin
        dead_nxt[reg_idx] = wr_time;
      end else if (recl_hit) begin
        recl_nxt[reg_idx] = wr_time;
      end
    end
    // Event set wins over clear
    irq_stat_nxt = irq_stat_nxt | evt;
    if (rd_en) begin
      prdata_nxt = '0;
      if (paddr == ADDR_CTRL) begin
        prdata_nxt[$bits(brs_ctrl_s)-1:0] = ctrl_r;
      end else if (paddr == ADDR_SHOT_EN) begin
        prdata_nxt[N_SHOTS-1:0] = shot_en_r;
      end else if (paddr == ADDR_GUARD) begin
        prdata_nxt[TIME_W-1:0] = guard_r;
      end else if (paddr == ADDR_STATUS) begin
        prdata_nxt[2:0] = st_r;
        prdata_nxt[6:4] = shot_r;
      end else if (paddr == ADDR_IRQ_STAT) begin
        prdata_nxt[IRQ_W-1:0] = irq_stat_r;
      end else if (paddr == ADDR_IRQ_MASK) begin
        prdata_nxt[IRQ_W-1:0] = irq_mask_r;
      end else if (dead_hit) begin
        prdata_nxt[TIME_W-1:0] = dead_r[reg_idx];
      end else if (recl_hit) begin
        prdata_nxt[TIME_W-1:0] = recl_r[reg_idx];
      end else begin
        pslverr_nxt = 1'b1;
      end
    end else if (psel && penable && !pready_r) begin
      pslverr_nxt = 1'b0;
    end
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r          <= ST_READY;
      shot_r        <= '0;
      closed_prev_r <= 1'b1;
      ctrl_r        <= CTRL_RST;
      shot_en_r     <= SHOT_EN_RST;
      guard_r       <= '0;
      dead_r        <= '{default: '0};
      recl_r        <= '{default: '0};
      irq_stat_r    <= '0;
      irq_mask_r    <= IRQ_MASK_RST;
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
      prdata_r      <= '0;
      seq_active_r  <= 1'b0;
      attempt_r     <= '0;
      close_req_r   <= 1'b0;
      guard_out_r   <= 1'b0;
      final_r       <= 1'b0;
      lock_r        <= 1'b0;
      irq_r         <= 1'b0;
    end else begin
      st_r          <= st_nxt;
      shot_r        <= shot_nxt;
      closed_prev_r <= brk.closed;
      ctrl_r        <= ctrl_nxt;
      shot_en_r     <= shot_en_nxt;
      guard_r       <= guard_nxt;
      dead_r        <= dead_nxt;
      recl_r        <= recl_nxt;
      irq_stat_r    <= irq_stat_nxt;
      irq_mask_r    <= irq_mask_nxt;
      pready_r      <= pready_nxt;
      pslverr_r     <= pslverr_nxt;
      prdata_r      <= prdata_nxt;
      seq_active_r  <= seq_active_nxt;
      attempt_r     <= attempt_nxt;
      close_req_r   <= close_req_nxt;
      guard_out_r   <= guard_out_nxt;
      final_r       <= final_nxt;
      lock_r        <= lock_nxt;
      irq_r         <= irq_nxt;
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign sequence_active     = seq_active_r;
  assign request_two_pending = seq_active_r;
  assign attempt_active      = attempt_r;
  assign close_request       = close_req_r;
  assign post_cycle_guard    = guard_out_r;
  assign final_trip          = final_r;
  assign reclose_lockout     = lock_r;
  assign irq                 = irq_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_final_lock;
    final_trip ##1 reclose_lockout;
  endsequence

  chk_start_flags: assert property (
    st_r == ST_READY && ctrl_r.enable && request_two && first_ok && !fail
    |=> sequence_active && request_two_pending && attempt_active[$past(first_idx)])
    else $error("Start indications missing");
  chk_dead_close: assert property (
    $rose(close_request) |-> $past(st_r) == ST_DEAD && $past(tmr_done)) else $error("Close without dead expiry");
  chk_close_hold: assert property (
    close_request && !brk.closed && !fail |=> close_request) else $error("Close dropped early");
  chk_shot_advance: assert property (
    st_r == ST_RECLAIM && request_two && next_ok && !fail
    |=> attempt_active == (N_SHOTS'(1) << $past(next_idx))) else $error("Attempt not advanced");
  chk_dead_full: assert property (
    st_r == ST_DEAD && !tmr_done && !fail |=> !close_request) else $error("Dead time cut short");
  chk_reclaim_end: assert property (
    st_r == ST_RECLAIM && tmr_done && !request_two && !fail
    |=> !sequence_active && attempt_active == '0 && (post_cycle_guard || $past(ctrl_r.skip_guard)))
    else $error("Reclaim end wrong");
  chk_guard_trip: assert property (
    st_r == ST_GUARD && request_two && !ctrl_r.guard_restart && !fail |=> s_final_lock)
    else $error("Guard fault not locked out");
  chk_zero_skip: assert property (
    st_r == ST_DEAD && limit == '0 && !fail |=> st_r == ST_CLOSE) else $error("Zero dead time not skipped");
  chk_skip_guard: assert property (
    st_r == ST_RECLAIM && tmr_done && !request_two && ctrl_r.skip_guard && !fail
    |=> st_r == ST_READY && !post_cycle_guard) else $error("Guard not omitted");
  chk_guard_ready: assert property (
    st_r == ST_GUARD && tmr_done && !request_two && !fail |=> st_r == ST_READY) else $error("Guard expiry missed");
  chk_final_lock: assert property (
    st_r == ST_RECLAIM && request_two && !next_ok && !fail |=> s_final_lock ##0 !sequence_active)
    else $error("No final trip at last shot");
  chk_lock_exit: assert property (
    reclose_lockout && !ext_reset && !(brk.closed && !closed_prev_r) |=> reclose_lockout)
    else $error("Lock-out left without cause");
  chk_fail_lock: assert property (
    fail && st_r != ST_READY |=> reclose_lockout) else $error("Failure did not lock out");

endmodule : brs_sequencer

// File: verification/brs_brk_model.sv
/*
  Behavioural breaker and object control model for the reclose sequencer.
  Assumes commands are levels synchronous to sys_clk; breaker starts closed.
*/
`timescale 1ns/1ps
module brs_brk_model import brs_pkg::*; (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Commands
  input  wire logic trip,
  input  wire logic close_cmd,
  input  wire logic man_close,
  input  wire logic fail_close,
  // Status
  output brs_brk_s  brk
);
  logic [1:0] cnt_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      brk   <= 4'h4;
      cnt_r <= 2'h0;
    end else begin
      cnt_r          <= 2'h0;
      brk.open_fail  <= 1'b0;
      brk.close_fail <= brk.close_fail & close_cmd & fail_close;
      if (brk.closed && trip) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == 2'h2) begin
          brk.open   <= 1'b1;
          brk.closed <= 1'b0;
        end
      end else if (brk.open && (close_cmd || man_close) && !brk.close_fail) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == 2'h3) begin
          if (fail_close && close_cmd) begin
            brk.close_fail <= 1'b1;
          end else begin
            brk.open   <= 1'b0;
            brk.closed <= 1'b1;
          end
        end
      end
    end
  end
endmodule : brs_brk_model

// File: verification/test_breaker_autoreclose_sequencer.sv
/*
  Self-checking bench for the reclose sequencer.
  Assumes the breaker model on the far side and TICKS set to 4.
*/
`timescale 1ns/1ps
module test_breaker_autoreclose_sequencer import brs_pkg::*; ;
  localparam int T = 4;
  logic sys_clk, rst, psel, penable, pwrite, request_two, ext_reset;
  logic man_close, fail_close, pready, pslverr, sequence_active;
  logic request_two_pending, close_request, post_cycle_guard;
  logic final_trip, reclose_lockout, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NUM_SHOTS-1:0] attempt_active;
  brs_brk_s brk;
  int miscompares, n_tests, n;

  brs_sequencer #(.N_SHOTS(NUM_SHOTS), .TICKS(T)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .request_two(request_two),
    .brk(brk), .ext_reset(ext_reset), .sequence_active(sequence_active),
    .request_two_pending(request_two_pending), .attempt_active(attempt_active),
    .close_request(close_request), .post_cycle_guard(post_cycle_guard),
    .final_trip(final_trip), .reclose_lockout(reclose_lockout), .irq(irq));
  brs_brk_model i_brk (.sys_clk(sys_clk), .rst(rst), .trip(request_two),
    .close_cmd(close_request), .man_close(man_close),
    .fail_close(fail_close), .brk(brk));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask : rng

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      miscompares++;
      stop_test;
    end
  endtask : apb

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  function automatic logic pick(input int k);
    case (k)
      0: return brk.open;
      1: return brk.closed;
      2: return close_request;
      3: return post_cycle_guard;
      4: return final_trip;
      default: return reclose_lockout;
    endcase
  endfunction : pick

  // Counts edges until the picked output shows v
  task wt(input int k, input logic v, input int mx, output int c);
    for (c = 1; c <= mx; c++) begin
      @(posedge sys_clk);
      if (pick(k) === v) return;
    end
    miscompares++;
    stop_test;
  endtask : wt

  task shot(input int dead, input logic [4:0] att, input bit pulse);
    int e;
    @(posedge sys_clk);
    request_two <= 1'b1;
    @(posedge sys_clk);
    #1 chk({sequence_active, request_two_pending, attempt_active}, {2'b11, att});
    wt(0, 1'b1, 50, n);
    request_two <= 1'b0;
    e = 0;
    if (pulse) begin
      repeat (3) @(posedge sys_clk);
      request_two <= 1'b1;
      @(posedge sys_clk);
      request_two <= 1'b0;
      e = 4;
    end
    wt(2, 1'b1, 2000, n);
    rng(n + e, dead * T, dead * T + 4);
    wt(1, 1'b1, 50, n);
    chk(close_request, 1);
    #1 chk(close_request, 0);
  endtask : shot

  task t_regs;
    rd(ADDR_CTRL, 32'h0000_0001, 1'b0);
    rd(ADDR_SHOT_EN, 32'h0000_0001, 1'b0);
    rd(ADDR_IRQ_MASK, 32'h0000_0000, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
    rd(12'h100, 32'h0000_0000, 1'b1);
    wr(ADDR_GUARD, 32'h000f_ffff);
    rd(ADDR_GUARD, {13'h0, TIME_MAX}, 1'b0);
  endtask : t_regs

  task t_two_shot;
    wr(ADDR_SHOT_EN, 32'h0000_0003);
    wr(ADDR_DEAD_BASE, 32'h0000_0002);
    wr(ADDR_DEAD_BASE + 12'h004, 32'h0000_0005);
    wr(ADDR_RECL_BASE, 32'h0000_0003);
    wr(ADDR_RECL_BASE + 12'h004, 32'h0000_0003);
    wr(ADDR_GUARD, 32'h0000_0003);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    shot(2, 5'h01, 1'b0);
    shot(5, 5'h02, 1'b1);
    wt(3, 1'b1, 200, n);
    rng(n, 3 * T, 3 * T + 5);
    #1 chk({sequence_active, request_two_pending, attempt_active}, 0);
    chk(irq, 0);
    wt(3, 1'b0, 50, n);
    rng(n, 3 * T, 3 * T + 2);
    chk(irq, 1);
    wr(ADDR_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 0);
    rd(ADDR_STATUS, 32'h0000_0010, 1'b0);
  endtask : t_two_shot

  task t_guard_fault;
    shot(2, 5'h01, 1'b0);
    wt(3, 1'b1, 200, n);
    request_two <= 1'b1;
    wt(4, 1'b1, 5, n);
    #1 chk({reclose_lockout, sequence_active}, 2'b10);
    repeat (4) @(posedge sys_clk);
    chk(sequence_active, 0);
    request_two <= 1'b0;
    ext_reset   <= 1'b1;
    wt(5, 1'b0, 10, n);
    ext_reset <= 1'b0;
    man_close <= 1'b1;
    wt(1, 1'b1, 20, n);
    man_close <= 1'b0;
  endtask : t_guard_fault

  task t_guard_restart;
    wr(ADDR_CTRL, 32'h0000_0003);
    shot(2, 5'h01, 1'b0);
    wt(3, 1'b1, 200, n);
    shot(2, 5'h01, 1'b0);
    wt(3, 1'b1, 200, n);
    wt(3, 1'b0, 200, n);
  endtask : t_guard_restart

  task t_final;
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_SHOT_EN, 32'h0000_0001);
    shot(2, 5'h01, 1'b0);
    @(posedge sys_clk);
    request_two <= 1'b1;
    wt(4, 1'b1, 20, n);
    #1 chk({sequence_active, request_two_pending, attempt_active, reclose_lockout}, 8'h01);
    wt(0, 1'b1, 20, n);
    request_two <= 1'b0;
    man_close   <= 1'b1;
    wt(5, 1'b0, 20, n);
    man_close <= 1'b0;
  endtask : t_final

  task t_zero;
    logic g;
    g = 1'b0;
    wr(ADDR_CTRL, 32'h0000_0005);
    wr(ADDR_DEAD_BASE, 32'h0000_0000);
    wr(ADDR_RECL_BASE, 32'h0000_0000);
    shot(0, 5'h01, 1'b0);
    repeat (6) begin
      @(posedge sys_clk);
      g = g | post_cycle_guard;
    end
    chk({sequence_active, g}, 0);
  endtask : t_zero

  task t_fail;
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_DEAD_BASE, 32'h0000_0002);
    fail_close  <= 1'b1;
    request_two <= 1'b1;
    wt(0, 1'b1, 50, n);
    request_two <= 1'b0;
    wt(5, 1'b1, 200, n);
    chk(reclose_lockout, 1);
    fail_close <= 1'b0;
    ext_reset  <= 1'b1;
    wt(5, 1'b0, 20, n);
    ext_reset <= 1'b0;
  endtask : t_fail

  initial begin
    {psel, penable, pwrite, request_two, ext_reset, man_close, fail_close} = '0;
    paddr  = '0;
    pwdata = '0;
    miscompares = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_two_shot;
    t_guard_fault;
    t_guard_restart;
    t_final;
    t_zero;
    t_fail;
    stop_test;
  end
endmodule : test_breaker_autoreclose_sequencer
